//--- hdl/bsc_pkg.sv
package bsc_pkg;

    // Widths of the core datapath
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int BIDX_W = 3;
    localparam int PC_W = 11;

    // Opcode nibbles in the top of the instruction word
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE = 4'h7;
    localparam logic [3:0] OPC_CALL = 4'h9;

    // Field positions inside the instruction word
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int BIDX_HI = 7;
    localparam int BIDX_LO = 5;
    localparam int FADDR_HI = 4;
    localparam int FADDR_LO = 0;
    localparam int LIT_HI = 7;
    localparam int LIT_LO = 0;

    // Page bits in the status register and their place in the program counter
    localparam int STAT_PAGE_HI = 6;
    localparam int STAT_PAGE_LO = 5;
    localparam int PC_PAGE_HI = 10;
    localparam int PC_PAGE_LO = 9;
    localparam int PC_ZERO_BIT = 8;

    // Constant words
    localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
    localparam logic [PC_W-1:0] RESET_PC = 11'h000;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;

    // Instruction classes handled by this block
    typedef enum logic [2:0]
    {
        OP_OTHER = 3'b000,
        OP_BIT_SET = 3'b001,
        OP_SKIP_ONE = 3'b010,
        OP_SKIP_ZERO = 3'b011,
        OP_CALL = 3'b100
    } bsc_op_e;

    // One-hot mask for a bit index
    function automatic logic [DATA_W-1:0] bsc_bit_mask(input logic [BIDX_W-1:0] idx);
        bsc_bit_mask = 8'h01 << idx;
    endfunction : bsc_bit_mask

endpackage : bsc_pkg

//--- hdl/bsc_dec_if.sv
`timescale 1ns/1ps
interface bsc_dec_if;
    import bsc_pkg::*;

    bsc_op_e op;
    logic [BIDX_W-1:0] bit_idx;
    logic [FADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] literal;

    // Decoder drives the fields, the executing core reads them
    modport dec (output op, output bit_idx, output file_addr, output literal);
    modport exe (input op, input bit_idx, input file_addr, input literal);

endinterface : bsc_dec_if

//--- hdl/bsc_decode.sv
`timescale 1ns/1ps
module bsc_decode
(
    // Instruction under execution
    input wire logic [bsc_pkg::INSTR_W-1:0] instr_in,
    // Decoded fields
    bsc_dec_if.dec dec
);
    import bsc_pkg::*;

    wire logic [3:0] opc;

    // Field extraction
    assign opc = instr_in[OPC_HI:OPC_LO];
    assign dec.bit_idx = instr_in[BIDX_HI:BIDX_LO];
    assign dec.file_addr = instr_in[FADDR_HI:FADDR_LO];
    assign dec.literal = instr_in[LIT_HI:LIT_LO];

    // Opcode classification
    assign dec.op = (opc == OPC_BIT_SET) ? OP_BIT_SET :
                    (opc == OPC_SKIP_ONE) ? OP_SKIP_ONE :
                    (opc == OPC_SKIP_ZERO) ? OP_SKIP_ZERO :
                    (opc == OPC_CALL) ? OP_CALL :
                    OP_OTHER;

endmodule : bsc_decode

//--- hdl/bsc_exec.sv
`timescale 1ns/1ps
module bsc_exec
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Program memory fetch, word at pc_out returned in the same cycle
    output logic [bsc_pkg::PC_W-1:0] pc_out,
    input wire logic [bsc_pkg::INSTR_W-1:0] fetch_word_in,
    // Status register page bits, from core logic on this clock
    input wire logic [bsc_pkg::DATA_W-1:0] status_in,
    // File register read port, combinational
    output logic [bsc_pkg::FADDR_W-1:0] file_raddr_out,
    input wire logic [bsc_pkg::DATA_W-1:0] file_rdata_in,
    // File register write port, committed at the end of the cycle it is high
    output logic file_we_out,
    output logic [bsc_pkg::FADDR_W-1:0] file_waddr_out,
    output logic [bsc_pkg::DATA_W-1:0] file_wdata_out,
    // Return stack push
    output logic stack_push_out,
    output logic [bsc_pkg::PC_W-1:0] stack_data_out,
    // Execution state
    output logic [bsc_pkg::INSTR_W-1:0] instr_out,
    output logic nop_cycle_out
);
    import bsc_pkg::*;

    bsc_dec_if dec_bus ();

    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] instr;
    logic nop_cycle;
    logic we;
    logic [FADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic push;
    logic [PC_W-1:0] push_data;

    wire logic [DATA_W-1:0] cur_data;
    wire logic [DATA_W-1:0] mask;
    wire logic sel_bit;
    wire logic skip_taken;
    wire logic is_call;
    wire logic is_set;
    wire logic flush;
    wire logic [PC_W-1:0] pc_inc;
    wire logic [PC_W-1:0] call_target;
    wire logic [PC_W-1:0] next_pc;
    wire logic [INSTR_W-1:0] next_instr;
    wire logic [DATA_W-1:0] next_wdata;

    // Decoder for the word in the execute slot
    bsc_decode u_decode
    (
        .instr_in (instr),
        .dec (dec_bus.dec)
    );

    // Operand read with bypass of a write still in flight
    assign file_raddr_out = dec_bus.file_addr;
    assign cur_data = (we && (waddr == dec_bus.file_addr)) ? wdata : file_rdata_in;
    assign mask = bsc_bit_mask(dec_bus.bit_idx);
    assign sel_bit = |(cur_data & mask);

    // Skip decision for both bit tests
    assign skip_taken = ((dec_bus.op == OP_SKIP_ONE) && sel_bit) ||
                        ((dec_bus.op == OP_SKIP_ZERO) && !sel_bit);
    assign is_call = (dec_bus.op == OP_CALL);
    assign is_set = (dec_bus.op == OP_BIT_SET);
    assign flush = skip_taken || is_call;

    // Read-modify-write value, only the chosen bit changes
    assign next_wdata = cur_data | mask;

    // Next program counter
    assign pc_inc = pc + PC_STEP;
    assign call_target = {status_in[STAT_PAGE_HI:STAT_PAGE_LO], 1'b0, dec_bus.literal};
    assign next_pc = is_call ? call_target : pc_inc;

    // Prefetched word is dropped and a no-op takes its slot
    assign next_instr = flush ? NOP_WORD : fetch_word_in;

    // Fetch and execute slot
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pc <= RESET_PC;
            instr <= NOP_WORD;
            nop_cycle <= 1'b0;
        end
        else
        begin
            pc <= next_pc;
            instr <= next_instr;
            nop_cycle <= flush;
        end
    end

    // File register write, flags are never written by these instructions
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            we <= 1'b0;
            waddr <= '0;
            wdata <= '0;
        end
        else
        begin
            we <= is_set;
            waddr <= dec_bus.file_addr;
            wdata <= next_wdata;
        end
    end

    // Return address push, pc already points past the call
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            push <= 1'b0;
            push_data <= RESET_PC;
        end
        else
        begin
            push <= is_call;
            push_data <= pc;
        end
    end

    // Outputs
    assign pc_out = pc;
    assign instr_out = instr;
    assign nop_cycle_out = nop_cycle;
    assign file_we_out = we;
    assign file_waddr_out = waddr;
    assign file_wdata_out = wdata;
    assign stack_push_out = push;
    assign stack_data_out = push_data;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    // Slot after a taken skip or call holds a no-op, then the normal stream resumes
    sequence seq_nop_slot;
        nop_cycle_out && (instr_out == NOP_WORD) ##1 !nop_cycle_out;
    endsequence

    sequence seq_skip_one_taken;
        (dec_bus.op == OP_SKIP_ONE) && sel_bit;
    endsequence

    sequence seq_skip_zero_taken;
        (dec_bus.op == OP_SKIP_ZERO) && !sel_bit;
    endsequence

    bit_set_write_a: assert property (
        is_set |=> file_we_out && (file_wdata_out == ($past(cur_data) | $past(mask)))
            && (file_waddr_out == $past(dec_bus.file_addr)))
        else $error("bit set did not write the masked value");

    skip_one_check_a: assert property (
        (dec_bus.op == OP_SKIP_ONE) |=> (nop_cycle_out == $past(sel_bit)))
        else $error("skip-if-one decision wrong");

    skip_one_nop_a: assert property (
        seq_skip_one_taken |=> seq_nop_slot)
        else $error("taken skip-if-one did not run a single no-op slot");

    skip_zero_check_a: assert property (
        (dec_bus.op == OP_SKIP_ZERO) |=> (nop_cycle_out == !$past(sel_bit)))
        else $error("skip-if-zero decision wrong");

    skip_zero_nop_a: assert property (
        seq_skip_zero_taken |=> seq_nop_slot ##0 (pc_out == $past(pc_out, 2) + PC_STEP + PC_STEP))
        else $error("taken skip-if-zero slot or counter wrong");

    call_push_a: assert property (
        is_call |=> stack_push_out && (stack_data_out == $past(pc_out)))
        else $error("call did not push the return address");

    call_low_pc_a: assert property (
        is_call |=> (pc_out[LIT_HI:LIT_LO] == $past(dec_bus.literal)))
        else $error("call literal not loaded");

    call_page_bits_a: assert property (
        is_call |=> (pc_out[PC_PAGE_HI:PC_PAGE_LO] == $past(status_in[STAT_PAGE_HI:STAT_PAGE_LO]))
            && !pc_out[PC_ZERO_BIT])
        else $error("call page bits wrong");

    call_two_cycles_a: assert property (
        is_call |=> seq_nop_slot)
        else $error("call did not take two cycles");

    write_only_set_a: assert property (
        file_we_out |-> $past(is_set))
        else $error("file write without a bit set");

    // Taken skip-if-one keeps the counter stepping by one through the no-op slot
    skip_one_step_a: assert property (
        seq_skip_one_taken |=> seq_nop_slot ##0 (pc_out == $past(pc_out, 2) + PC_STEP + PC_STEP))
        else $error("taken skip-if-one slot or counter wrong");

    // A flushed slot always carries the no-op word
    nop_slot_word_a: assert property (
        nop_cycle_out |-> (instr_out == NOP_WORD))
        else $error("no-op slot did not hold the no-op word");

    // Pushes only follow a call in the execute slot
    push_only_call_a: assert property (
        stack_push_out |-> $past(is_call))
        else $error("return address pushed without a call");

    // The no-op slot itself has no side effect
    flush_no_write_a: assert property (
        nop_cycle_out |=> !file_we_out && !stack_push_out)
        else $error("no-op slot caused a write or a push");

endmodule : bsc_exec

//--- dv/tb_bit_ops_and_subroutine_call.sv
`timescale 1ns/1ps
module tb_bit_ops_and_subroutine_call;
    import bsc_pkg::*;

    // Clock, reset and design ports
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [PC_W-1:0] pc_out;
    logic [INSTR_W-1:0] fetch_word_in;
    logic [DATA_W-1:0] status_in = 8'h00;
    logic [FADDR_W-1:0] file_raddr_out;
    logic [DATA_W-1:0] file_rdata_in;
    logic file_we_out;
    logic [FADDR_W-1:0] file_waddr_out;
    logic [DATA_W-1:0] file_wdata_out;
    logic stack_push_out;
    logic [PC_W-1:0] stack_data_out;
    logic [INSTR_W-1:0] instr_out;
    logic nop_cycle_out;

    // Program, status and file storage; model holds the expected register contents
    logic [INSTR_W-1:0] pmem [0:2047];
    logic [DATA_W-1:0] smem [0:2047];
    logic [DATA_W-1:0] regs [0:31];
    logic [DATA_W-1:0] model [0:31];
    logic [25:0] notes [$];
    logic [25:0] exp_note;
    logic [31:0] seed = 32'h18c99fea;
    logic [PC_W-1:0] targets [0:4] = '{11'h000, 11'h0c0, 11'h2ff, 11'h600, 11'h4a5};
    int failures = 0;
    int comparisons = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    bsc_exec i_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pc_out(pc_out),
        .fetch_word_in(fetch_word_in), .status_in(status_in),
        .file_raddr_out(file_raddr_out), .file_rdata_in(file_rdata_in),
        .file_we_out(file_we_out), .file_waddr_out(file_waddr_out),
        .file_wdata_out(file_wdata_out), .stack_push_out(stack_push_out),
        .stack_data_out(stack_data_out), .instr_out(instr_out), .nop_cycle_out(nop_cycle_out)
    );

    // Program and file memories answer in the same cycle, status one cycle later; writes land at the end of the pulse cycle
    assign fetch_word_in = pmem[pc_out];
    assign file_rdata_in = regs[file_raddr_out];
    always @(posedge clk_sys_in)
    begin
        status_in <= smem[pc_out];
        if (file_we_out === 1'b1)
            regs[file_waddr_out] <= file_wdata_out;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr

    task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Place one word with a random status value beside it
    task automatic put(inout logic [PC_W-1:0] a, input logic [INSTR_W-1:0] w);
        seed = lfsr(seed);
        pmem[a] = w;
        smem[a] = seed[7:0];
        a = a + PC_STEP;
    endtask : put

    // Bit set; a skipped one leaves no note and no change
    task automatic emit_set(inout logic [PC_W-1:0] a, input logic [4:0] f, input logic [2:0] b,
                            input logic live);
        put(a, {OPC_BIT_SET, b, f});
        if (live)
        begin
            notes.push_back({2'd1, 11'h000, f, model[f] | (8'h01 << b)});
            model[f] = model[f] | (8'h01 << b);
        end
    endtask : emit_set

    // Watcher: each result pulse takes the oldest note
    always @(negedge clk_sys_in)
    begin
        if (rst_n_in === 1'b1 && (file_we_out | stack_push_out | nop_cycle_out) !== 1'b0)
        begin
            exp_note = (notes.size() > 0) ? notes.pop_front() : 26'h3ffffff;
            if (file_we_out === 1'b1)
                check("file write", {2'd1, 11'h000, file_waddr_out, file_wdata_out}, exp_note);
            else if (stack_push_out === 1'b1)
                check("call", {2'd2, nop_cycle_out, 1'b0, stack_data_out, pc_out}, exp_note);
            else
                check("skip slot", {2'd3, 12'h000, instr_out}, exp_note);
        end
    end

    // Build a chain of segments joined by calls, then run it
    initial
    begin : main
        logic [PC_W-1:0] a;
        logic [4:0] f;
        logic [2:0] b;
        logic taken;
        int k;
        int j;
        for (k = 0; k < 2048; k++)
        begin
            seed = lfsr(seed);
            pmem[k] = NOP_WORD;
            smem[k] = seed[7:0];
        end
        for (k = 0; k < 32; k++)
        begin
            seed = lfsr(seed);
            regs[k] = seed[7:0];
            model[k] = seed[7:0];
        end
        for (j = 0; j < 4; j++)
        begin
            a = targets[j];
            repeat (10)
            begin
                seed = lfsr(seed);
                f = seed[8] ? 5'h1f : {3'b000, seed[10:9]};
                b = seed[15:13];
                if (seed[1:0] == 2'd1 || seed[1:0] == 2'd2)
                begin
                    taken = (seed[1:0] == 2'd1) ? model[f][b] : !model[f][b];
                    put(a, {(seed[1:0] == 2'd1) ? OPC_SKIP_ONE : OPC_SKIP_ZERO, b, f});
                    if (taken)
                        notes.push_back({2'd3, 12'h000, NOP_WORD});
                    emit_set(a, f, b + 3'h3, !taken);
                end
                else
                    emit_set(a, f, b, 1'b1);
            end
            notes.push_back({2'd2, 2'b10, a + PC_STEP, targets[j + 1]});
            put(a, {OPC_CALL, targets[j + 1][7:0]});
            smem[a - PC_STEP][6:5] = targets[j + 1][10:9];
        end
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("reset pc", {15'h0000, pc_out}, {15'h0000, RESET_PC});
        check("reset slot", {14'h0000, instr_out}, {14'h0000, NOP_WORD});
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        k = 0;
        while (notes.size() > 0 && k < 2000)
        begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= 2000)
            failures++;
        repeat (40) @(posedge clk_sys_in);
        conclude();
    end

endmodule : tb_bit_ops_and_subroutine_call
